//--- hdl/hp_amp_control.v
// Headphone amplifier control register bank behind an I2C slave
// Operation
// - I2C slave giving read access to every register, write access to all but info.
// - 7-bit address; C0h writes, C1h reads; master sends these.
// - Registers at 1h enable, 2h volume, 3h float, 4h info.
// - Enable bits 7 left, 6 right; reset to 0, disabled.
// - Enable bit 1 thermal flag: sticky, cleared by read, resets 0.
// - Enable bit 0 software power down, read-write, resets to 1.
// - Power down turns off buck, charge pump and both outputs.
// - Entering or leaving power down changes no register contents.
// - Register access continues during power down.
// - Volume bits 7 and 6 mute left and right; reset to 1.
// - Volume bits 5:1 hold gain code, reset 0; 27 is 0 dB.
// - Float bits 1 left, 0 right set high impedance; reset 0.
// - Info register read-only: supplier code bits 7:6, version bits 3:0.
// - Overtemperature detector forces shutdown and sets the thermal flag.
`timescale 1ns/1ps
`default_nettype none
`include "hp_amp_regs.vh"

module hp_amp_control
#(
	// Identity codes; values are arbitrary
	parameter [1:0] SUPPLIER_CODE = 2'h2,
	parameter [3:0] VERSION_CODE = 4'h5
)
(
	// Clock and reset
	input wire REF_CLK,
	input wire SYS_RST,
	// I2C pins
	input wire SCL_IN,
	input wire SDA_IN,
	output wire SDA_OUT,
	output reg SDA_OE,
	// Overtemperature detector level
	input wire OVER_TEMP,
	// Analog controls
	output reg BUCK_ON,
	output reg CHARGE_PUMP_ON,
	output reg LEFT_OUTPUT_PIN_DRIVE,
	output reg RIGHT_OUTPUT_PIN_DRIVE,
	output reg LEFT_MUTE,
	output reg RIGHT_MUTE,
	output reg LEFT_OUTPUT_FLOAT,
	output reg RIGHT_OUTPUT_FLOAT,
	output reg [4:0] GAIN_CODE,
	output reg GAIN_IS_UNITY
);

	localparam ST_IDLE = 2'd0;
	localparam ST_ADDR = 2'd1;
	localparam ST_REG = 2'd2;
	localparam ST_DATA = 2'd3;

	// *****************************************
	// Register state
	// *****************************************
	reg left_channel_enable;
	reg right_channel_enable;
	reg sticky_clear_on_read;
	reg software_power_down;
	reg [7:0] volume;
	reg left_output_float;
	reg right_output_float;
	reg [7:0] reg_ptr;
	reg [1:0] state;
	reg read_mode;
	reg ack_byte;
	reg [1:0] next_state;

	wire start_seen;
	wire stop_seen;
	wire byte_valid;
	wire [7:0] byte_data;
	wire tx_load;
	wire sda_oe_int;
	wire write_strobe;

	function [7:0] read_reg;
		input [7:0] addr;
		begin
			case (addr)
				`REG_ADDR_ENABLE: read_reg = {left_channel_enable, right_channel_enable,
					4'h0, sticky_clear_on_read, software_power_down};
				`REG_ADDR_VOLUME: read_reg = volume & `VOLUME_WMASK;
				`REG_ADDR_FLOAT: read_reg = {6'h00, left_output_float, right_output_float};
				`REG_ADDR_INFO: read_reg = {SUPPLIER_CODE, 2'h0, VERSION_CODE};
				default: read_reg = 8'h00;
			endcase
		end
	endfunction

	// Pointer advance after each data byte
	function [7:0] ptr_step;
		input [7:0] ptr;
		begin
			ptr_step = ptr + 8'h01;
		end
	endfunction

	// Buck, pump and both amplifiers share one power condition
	function run_allowed;
		input power_down;
		input hot;
		begin
			run_allowed = ~power_down & ~hot;
		end
	endfunction

	wire [7:0] tx_data = read_reg(reg_ptr);

	i2c_byte_slave u_bits
	(
		.clk(REF_CLK),
		.rst(SYS_RST),
		.scl_in(SCL_IN),
		.sda_in(SDA_IN),
		.sda_oe(sda_oe_int),
		.start_seen(start_seen),
		.stop_seen(stop_seen),
		.byte_valid(byte_valid),
		.byte_data(byte_data),
		.ack_byte(ack_byte),
		.tx_data(tx_data),
		.tx_mode(read_mode),
		.tx_load(tx_load)
	);

	// Open-drain: only ever pull low
	assign SDA_OUT = 1'b0;

	// *****************************************
	// Transfer sequencing
	// *****************************************
	always @*
	begin
		next_state = state;
		ack_byte = 1'b0;
		case (state)
			ST_ADDR: ack_byte = (byte_data[7:1] == `SLAVE_ADDR_7);
			ST_REG: ack_byte = 1'b1;
			ST_DATA: ack_byte = 1'b1;
			default: ack_byte = 1'b0;
		endcase
		if (start_seen)
			next_state = ST_ADDR;
		else if (stop_seen)
			next_state = ST_IDLE;
		else if (byte_valid)
		begin
			case (state)
				ST_ADDR: next_state = !ack_byte ? ST_IDLE
					: (byte_data[0] ? ST_DATA : ST_REG);
				ST_REG: next_state = ST_DATA;
				ST_DATA: next_state = ST_DATA;
				default: next_state = ST_IDLE;
			endcase
		end
	end

	// *****************************************
	// Transfer control
	// *****************************************
	always @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			state <= ST_IDLE;
			read_mode <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (start_seen)
				read_mode <= 1'b0;
			else if (byte_valid && state == ST_ADDR && ack_byte)
				read_mode <= byte_data[0];
		end
	end

	// *****************************************
	// Register pointer
	// *****************************************
	// Not cleared by STOP, so a later access can rely on the last pointer
	assign write_strobe = byte_valid && (state == ST_DATA) && !read_mode;

	always @(posedge REF_CLK)
	begin
		if (SYS_RST)
			reg_ptr <= 8'h00;
		else if (byte_valid && state == ST_REG)
			reg_ptr <= byte_data;
		else if (write_strobe || tx_load)
			reg_ptr <= ptr_step(reg_ptr);
	end

	// *****************************************
	// Control registers
	// *****************************************
	always @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			left_channel_enable <= 1'b0;
			right_channel_enable <= 1'b0;
			software_power_down <= 1'b1;
			volume <= `VOLUME_RESET;
			left_output_float <= 1'b0;
			right_output_float <= 1'b0;
		end
		// Power down is never consulted, so accesses and contents carry through it
		else if (write_strobe)
		begin
			// Only bits 7, 6 and 0 are taken, so enables follow the written value and the thermal flag is not written
			case (reg_ptr)
				`REG_ADDR_ENABLE:
				begin
					left_channel_enable <= byte_data[`EN_LEFT_BIT];
					right_channel_enable <= byte_data[`EN_RIGHT_BIT];
					software_power_down <= byte_data[`EN_POWER_DOWN_BIT];
				end
				`REG_ADDR_VOLUME: volume <= byte_data & `VOLUME_WMASK;
				`REG_ADDR_FLOAT:
				begin
					left_output_float <= byte_data[`FLOAT_LEFT_BIT];
					right_output_float <= byte_data[`FLOAT_RIGHT_BIT];
				end
				default: ;
			endcase
		end
	end

	// *****************************************
	// Thermal status flag
	// *****************************************
	// Cleared only once the enable byte is loaded for sending, so that read
	// still returns the set flag; set wins over the clear
	always @(posedge REF_CLK)
	begin
		if (SYS_RST)
			sticky_clear_on_read <= 1'b0;
		else if (OVER_TEMP)
			sticky_clear_on_read <= 1'b1;
		else if (tx_load && reg_ptr == `REG_ADDR_ENABLE)
			sticky_clear_on_read <= 1'b0;
	end

	// *****************************************
	// Bus pin
	// *****************************************
	always @(posedge REF_CLK)
	begin
		if (SYS_RST)
			SDA_OE <= 1'b0;
		else
			SDA_OE <= sda_oe_int;
	end

	// *****************************************
	// Power controls
	// *****************************************
	// Detector level acts at once, so a hot die loses power even mid-transfer
	always @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			BUCK_ON <= 1'b0;
			CHARGE_PUMP_ON <= 1'b0;
			LEFT_OUTPUT_PIN_DRIVE <= 1'b0;
			RIGHT_OUTPUT_PIN_DRIVE <= 1'b0;
		end
		else
		begin
			BUCK_ON <= run_allowed(software_power_down, OVER_TEMP);
			CHARGE_PUMP_ON <= run_allowed(software_power_down, OVER_TEMP);
			LEFT_OUTPUT_PIN_DRIVE <= left_channel_enable
				& run_allowed(software_power_down, OVER_TEMP);
			RIGHT_OUTPUT_PIN_DRIVE <= right_channel_enable
				& run_allowed(software_power_down, OVER_TEMP);
		end
	end

	// *****************************************
	// Channel settings
	// *****************************************
	// Mute and float ignore power state; the analog side lays them over the drive
	always @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			LEFT_MUTE <= 1'b1;
			RIGHT_MUTE <= 1'b1;
			LEFT_OUTPUT_FLOAT <= 1'b0;
			RIGHT_OUTPUT_FLOAT <= 1'b0;
			GAIN_CODE <= 5'h00;
			GAIN_IS_UNITY <= 1'b0;
		end
		else
		begin
			LEFT_MUTE <= volume[`VOL_MUTE_L_BIT];
			RIGHT_MUTE <= volume[`VOL_MUTE_R_BIT];
			LEFT_OUTPUT_FLOAT <= left_output_float;
			RIGHT_OUTPUT_FLOAT <= right_output_float;
			GAIN_CODE <= volume[`VOL_GAIN_MSB:`VOL_GAIN_LSB];
			GAIN_IS_UNITY <= (volume[`VOL_GAIN_MSB:`VOL_GAIN_LSB] == `GAIN_UNITY);
		end
	end

endmodule // hp_amp_control

`default_nettype wire

//--- hdl/hp_amp_regs.vh
// Register map, field positions, reset values and bus constants of the amplifier control bank
`ifndef HP_AMP_REGS_VH
`define HP_AMP_REGS_VH

// *****************************************
// Bus addressing
// *****************************************
`define SLAVE_ADDR_7 7'h60
`define REG_ADDR_ENABLE 8'h01
`define REG_ADDR_VOLUME 8'h02
`define REG_ADDR_FLOAT 8'h03
`define REG_ADDR_INFO 8'h04

// *****************************************
// Field positions
// *****************************************
`define EN_LEFT_BIT 7
`define EN_RIGHT_BIT 6
`define EN_THERMAL_BIT 1
`define EN_POWER_DOWN_BIT 0
`define VOL_MUTE_L_BIT 7
`define VOL_MUTE_R_BIT 6
`define VOL_GAIN_MSB 5
`define VOL_GAIN_LSB 1
`define FLOAT_LEFT_BIT 1
`define FLOAT_RIGHT_BIT 0

// *****************************************
// Reset values and masks
// *****************************************
`define ENABLE_RESET 8'h01
`define VOLUME_RESET 8'hc0
`define FLOAT_RESET 8'h00
`define ENABLE_WMASK 8'hc1
`define VOLUME_WMASK 8'hfe
`define FLOAT_WMASK 8'h03
`define GAIN_UNITY 5'h1b

`endif

//--- hdl/i2c_byte_slave.v
// Bit-level I2C slave engine: start/stop detect, byte shifting, acknowledge and SDA drive
`timescale 1ns/1ps
`default_nettype none

module i2c_byte_slave
(
	input wire clk,
	input wire rst,
	// Bus pins, sampled synchronously
	input wire scl_in,
	input wire sda_in,
	output reg sda_oe,
	// Byte events toward the register file
	output reg start_seen,
	output reg stop_seen,
	output reg byte_valid,
	output reg [7:0] byte_data,
	input wire ack_byte,
	input wire [7:0] tx_data,
	input wire tx_mode,
	output reg tx_load
);

	reg scl_q;
	reg sda_q;
	reg [3:0] bit_cnt;
	reg [7:0] shift;
	reg in_ack;
	reg ack_drive;
	reg active;
	reg master_nack;
	reg sending;

	wire scl_rise = scl_in & ~scl_q;
	wire scl_fall = ~scl_in & scl_q;

	always @(posedge clk)
	begin
		if (rst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			in_ack <= 1'b0;
			ack_drive <= 1'b0;
			active <= 1'b0;
			master_nack <= 1'b0;
			sending <= 1'b0;
			sda_oe <= 1'b0;
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
			byte_valid <= 1'b0;
			byte_data <= 8'h00;
			tx_load <= 1'b0;
		end
		else
		begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
			byte_valid <= 1'b0;
			tx_load <= 1'b0;
			if (scl_in && scl_q && sda_q && !sda_in)
			begin
				// Start or repeated start
				start_seen <= 1'b1;
				sending <= 1'b0;
				active <= 1'b1;
				bit_cnt <= 4'h0;
				in_ack <= 1'b0;
				sda_oe <= 1'b0;
			end
			else if (scl_in && scl_q && !sda_q && sda_in)
			begin
				stop_seen <= 1'b1;
				active <= 1'b0;
				sda_oe <= 1'b0;
			end
			else if (active && scl_rise)
			begin
				if (in_ack)
					master_nack <= sda_in;
				else
				begin
					shift <= {shift[6:0], sda_in};
					bit_cnt <= bit_cnt + 4'h1;
					if (bit_cnt == 4'h7)
					begin
						byte_valid <= 1'b1;
						byte_data <= {shift[6:0], sda_in};
					end
				end
			end
			else if (active && scl_fall)
			begin
				if (!in_ack && bit_cnt == 4'h8)
				begin
					// Enter acknowledge slot
					in_ack <= 1'b1;
					// A read address byte is still ours to acknowledge
					ack_drive <= (tx_mode && sending) ? 1'b0 : ack_byte;
					sda_oe <= (tx_mode && sending) ? 1'b0 : ack_byte;
				end
				else if (in_ack)
				begin
					in_ack <= 1'b0;
					bit_cnt <= 4'h0;
					if (tx_mode && !master_nack)
					begin
						tx_load <= 1'b1;
						sending <= 1'b1;
						shift <= tx_data;
						sda_oe <= ~tx_data[7];
					end
					else if (!tx_mode && !ack_drive)
					begin
						active <= 1'b0;
						sda_oe <= 1'b0;
					end
					else
						sda_oe <= 1'b0;
					if (tx_mode && master_nack)
						active <= 1'b0;
				end
				else if (tx_mode)
					sda_oe <= ~shift[7];
			end
		end
	end

endmodule // i2c_byte_slave

`default_nettype wire

//--- tb/i2c_host_model.sv
// I2C bus master model that drives the amplifier control bank
`timescale 1ns/1ps
`default_nettype none
// ****
// Master
// ****
module i2c_host_model
(
	// Clock and resolved data line
	input wire logic clk,
	input wire logic sda,
	// Bus drive, 1 on sda_o releases the line
	output logic scl_o,
	output logic sda_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Five clocks a phase keeps clear of the slave's two-sample filter
	task automatic hold();
		repeat (5) @(posedge clk);
		#1;
	endtask
	task automatic bitx(input logic b, output logic r);
		@(posedge clk);
		#1 sda_o = b;
		hold();
		scl_o = 1'b1;
		hold();
		r = sda;
		scl_o = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(1'b1, a);
		ack = !a;
	endtask
	task automatic start();
		@(posedge clk);
		#1 sda_o = 1'b1;
		hold();
		scl_o = 1'b1;
		hold();
		sda_o = 1'b0;
		hold();
		scl_o = 1'b0;
	endtask
	task automatic stop();
		@(posedge clk);
		#1 sda_o = 1'b0;
		hold();
		scl_o = 1'b1;
		hold();
		sda_o = 1'b1;
		hold();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic k1, k2, k3;
		start();
		xfer(8'hc0, q, k1);
		xfer(a, q, k2);
		xfer(d, q, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		logic k;
		start();
		xfer(8'hc0, q, k);
		xfer(a, q, k);
		start();
		xfer(8'hc1, q, k);
		xfer(8'hff, d, k);
		stop();
	endtask
endmodule // i2c_host_model
`default_nettype wire

//--- tb/hp_amp_control_sva.sv
// Port-level assertions for the amplifier control bank
`timescale 1ns/1ps
`default_nettype none
module hp_amp_control_chk
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	// Bus and detector
	input wire logic SCL_IN,
	input wire logic SDA_OE,
	input wire logic OVER_TEMP,
	// Analog controls
	input wire logic BUCK_ON,
	input wire logic CHARGE_PUMP_ON,
	input wire logic LEFT_OUTPUT_PIN_DRIVE,
	input wire logic RIGHT_OUTPUT_PIN_DRIVE,
	input wire logic LEFT_MUTE,
	input wire logic RIGHT_MUTE,
	input wire logic LEFT_OUTPUT_FLOAT,
	input wire logic RIGHT_OUTPUT_FLOAT,
	input wire logic [4:0] GAIN_CODE,
	input wire logic GAIN_IS_UNITY
);
	// ****
	// Properties
	// ****
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	property p_rst_out;
		$fell(SYS_RST) |-> LEFT_MUTE && RIGHT_MUTE && !BUCK_ON && GAIN_CODE == 5'h00;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("bad reset outputs");
	property p_unity;
		GAIN_IS_UNITY == (GAIN_CODE == 5'h1b);
	endproperty
	a_unity: assert property (p_unity) else $error("unity flag wrong");
	property p_drive_pwr;
		(LEFT_OUTPUT_PIN_DRIVE || RIGHT_OUTPUT_PIN_DRIVE) |-> BUCK_ON;
	endproperty
	a_drive_pwr: assert property (p_drive_pwr) else $error("drive while down");
	property p_pump;
		CHARGE_PUMP_ON == BUCK_ON;
	endproperty
	a_pump: assert property (p_pump) else $error("pump and buck differ");
	property p_hot;
		OVER_TEMP |=> !BUCK_ON && !LEFT_OUTPUT_PIN_DRIVE && !RIGHT_OUTPUT_PIN_DRIVE;
	endproperty
	a_hot: assert property (p_hot) else $error("hot but powered");
	property p_cool;
		$rose(BUCK_ON) |-> !$past(OVER_TEMP);
	endproperty
	a_cool: assert property (p_cool) else $error("power up while hot");
	// Data may only move with SCL low, else it would be a start or stop
	property p_oe_scl;
		$changed(SDA_OE) |-> !SCL_IN;
	endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("SDA moved with SCL high");
	property p_oe_hold;
		$rose(SDA_OE) |-> SDA_OE [*3];
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("SDA drive too short");
	property p_cfg;
		$changed({LEFT_MUTE, RIGHT_MUTE, GAIN_CODE, LEFT_OUTPUT_FLOAT}) |-> SCL_IN;
	endproperty
	a_cfg: assert property (p_cfg) else $error("setting moved off a bus write");
endmodule // hp_amp_control_chk
`default_nettype wire

//--- tb/headphone_amp_control_regs_test.sv
// Self-checking bench for the amplifier control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module headphone_amp_control_regs_test;
	// ****
	// Bench
	// ****
	localparam logic [1:0] SUP = 2'h2;
	localparam logic [3:0] VER = 4'h5;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hot = 1'b0;
	logic scl;
	logic sda_m;
	logic [7:0] v;
	logic ok;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	wire sda_oe, sda_out, buck, cp, drv_l, drv_r, mute_l, mute_r, flt_l, flt_r, unity;
	wire [4:0] gain;
	// Open-drain line with a pull-up
	wire sda = sda_m & (sda_oe ? sda_out : 1'b1);
	always #50 clk = ~clk;
	hp_amp_control #(.SUPPLIER_CODE(SUP), .VERSION_CODE(VER)) u_hp_amp_control (
		.REF_CLK(clk), .SYS_RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
		.SDA_OE(sda_oe), .OVER_TEMP(hot), .BUCK_ON(buck), .CHARGE_PUMP_ON(cp),
		.LEFT_OUTPUT_PIN_DRIVE(drv_l), .RIGHT_OUTPUT_PIN_DRIVE(drv_r),
		.LEFT_MUTE(mute_l), .RIGHT_MUTE(mute_r), .LEFT_OUTPUT_FLOAT(flt_l),
		.RIGHT_OUTPUT_FLOAT(flt_r), .GAIN_CODE(gain), .GAIN_IS_UNITY(unity));
	i2c_host_model u_i2c_host_model (.clk(clk), .sda(sda), .scl_o(scl), .sda_o(sda_m));
	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string n);
		u_i2c_host_model.rd(a, v);
		`CHK(n, e, v)
	endtask
	task automatic wchk(input logic [7:0] a, input logic [7:0] d);
		u_i2c_host_model.wr(a, d, ok);
		`CHK("ack", 1'b1, ok)
	endtask
	task automatic t_reset();
		`CHK("mute", 2'b11, {mute_l, mute_r})
		`CHK("power", 4'h0, {buck, cp, drv_l, drv_r})
		`CHK("gain", 5'h00, gain)
		`CHK("float", 2'b00, {flt_l, flt_r})
		`CHK("sda out", 1'b0, sda_out)
		rchk(8'h01, 8'h01, "enable");
		rchk(8'h02, 8'hc0, "volume");
		rchk(8'h03, 8'h00, "float");
		rchk(8'h04, {SUP, 2'b00, VER}, "info");
	endtask
	task automatic t_rw();
		wchk(8'h02, 8'hff);
		rchk(8'h02, 8'hfe, "volume");
		`CHK("gain", 6'h3e, {gain, unity})
		wchk(8'h02, 8'h36);
		`CHK("gain", 8'h37, {mute_l, mute_r, gain, unity})
		wchk(8'h03, 8'hff);
		rchk(8'h03, 8'h03, "float");
		`CHK("float", 2'b11, {flt_l, flt_r})
		wchk(8'h01, 8'hff);
		rchk(8'h01, 8'hc1, "enable");
		wchk(8'h01, 8'hc0);
		`CHK("power", 4'hf, {buck, cp, drv_l, drv_r})
	endtask
	task automatic t_shutdown();
		wchk(8'h01, 8'hc1);
		`CHK("power", 4'h0, {buck, cp, drv_l, drv_r})
		wchk(8'h03, 8'h01);
		rchk(8'h02, 8'h36, "volume");
		rchk(8'h03, 8'h01, "float");
		wchk(8'h01, 8'h00);
		`CHK("power", 4'hc, {buck, cp, drv_l, drv_r})
		wchk(8'h01, 8'hc0);
		`CHK("power", 4'hf, {buck, cp, drv_l, drv_r})
	endtask
	task automatic t_thermal();
		@(posedge clk);
		#1 hot = 1'b1;
		repeat (3) @(posedge clk);
		#1 `CHK("power", 4'h0, {buck, cp, drv_l, drv_r})
		hot = 1'b0;
		repeat (3) @(posedge clk);
		#1 `CHK("power", 4'hf, {buck, cp, drv_l, drv_r})
		rchk(8'h01, 8'hc2, "enable");
		rchk(8'h01, 8'hc0, "enable");
	endtask
	task automatic t_refuse();
		u_i2c_host_model.wr(8'h04, 8'h00, ok);
		rchk(8'h04, {SUP, 2'b00, VER}, "info");
		u_i2c_host_model.wr(8'h05, 8'hff, ok);
		rchk(8'h05, 8'h00, "unmapped");
		rchk(8'h03, 8'h01, "float");
		u_i2c_host_model.start();
		u_i2c_host_model.xfer(8'h42, v, ok);
		u_i2c_host_model.stop();
		`CHK("nack", 1'b0, ok)
		rchk(8'h02, 8'h36, "volume");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 60000)
		begin
			n_fail++;
			conclude();
		end
	end
	initial
	begin
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		t_reset();
		t_rw();
		t_shutdown();
		t_thermal();
		t_refuse();
		conclude();
	end
endmodule // headphone_amp_control_regs_test
bind hp_amp_control hp_amp_control_chk u_hp_amp_control_chk (.REF_CLK, .SYS_RST,
	.SCL_IN, .SDA_OE, .OVER_TEMP, .BUCK_ON, .CHARGE_PUMP_ON, .LEFT_OUTPUT_PIN_DRIVE,
	.RIGHT_OUTPUT_PIN_DRIVE, .LEFT_MUTE, .RIGHT_MUTE, .LEFT_OUTPUT_FLOAT,
	.RIGHT_OUTPUT_FLOAT, .GAIN_CODE, .GAIN_IS_UNITY);
`default_nettype wire
